//--- design/sep_device.sv
`timescale 1ns/10ps
// Summary of operation
// - Opcodes 06 set, 04 clear, 05 status read
// - Opcodes 01 status write, 03/02 array
// - Unknown opcode: ignore input until reselected
// - Master sets write latch before writes
// - Latch opcodes then wait for deselect
// - Latch clears on reset, clear, write end
// - Status read always allowed, repeats while selected
// - Busy flag high during self-timed cycle
// - Latch low refuses writes; latch visible
// - Guard bits refuse array writes in region
// - Lock plus protect low refuses status write
// - Status write needs deselect at byte edge
// - Status write starts timed cycle, then clears
// - New status values apply after cycle ends
// - Bits 6..4 read zero; others untouched
// - Lock clear: status write needs latch only
// - Lock set, protect high: latch suffices
// - Hard mode entered in either order
// - Only protect pin high, reset, or end of an earlier lock-clearing status write leaves hard mode
// - Low twelve address bits used, rest ignored
// - Guard code selects none/quarter/half/whole
// - Writes need whole bytes of clocks
module sep_device
  import sep_pkg::*;
#(
  parameter int WRITE_CYC = SEP_WRITE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  sep_link_if.dev link,
  output logic busy_flag,
  output logic write_latch_bit,
  output logic guard_hi_bit,
  output logic guard_lo_bit,
  output logic status_lock_bit,
  output logic hard_guard_mode,
  output logic [15:0] arr_addr,
  input wire logic [7:0] arr_rd_byte,
  output logic arr_wr_vld,
  output logic [7:0] arr_wr_byte,
  output logic arr_wr_commit
);

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_OPC = 8'h02,
    ST_WAIT = 8'h04,
    ST_SRD = 8'h08,
    ST_SWR = 8'h10,
    ST_ADR = 8'h20,
    ST_ARD = 8'h40,
    ST_AWR = 8'h80
  } sep_dev_st_t;

  sep_dev_st_t st;
  sep_dev_st_t next_st;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [2:0] bcnt;
  logic [7:0] sr;
  logic abyte;
  logic got;
  logic [7:0] op;
  logic [2:0] pend;
  logic pend_st;
  logic [31:0] timer;
  logic [7:0] osr;
  logic [2:0] ocnt;
  logic miso_q;
  logic oe_q;
  logic [7:0] status_byte;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages before use; third stage only feeds edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1 <= SEP_PIN_IDLE;
      pin_s2 <= SEP_PIN_IDLE;
      pin_s3 <= SEP_PIN_IDLE;
    end else begin
      pin_s1 <= {link.sel_n, link.sclk, link.mosi, link.wp_n};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Edges of select and link clock; clock edges count only when selected
  wire logic sel_rise = pin_s2[3] & ~pin_s3[3];
  wire logic sel_fall = ~pin_s2[3] & pin_s3[3];
  wire logic sck_rise = ~pin_s2[3] & pin_s2[2] & ~pin_s3[2];
  wire logic sck_fall = ~pin_s2[3] & ~pin_s2[2] & pin_s3[2];
  wire logic din = pin_s2[1];
  wire logic wp_n_s = pin_s2[0];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [7:0] next_sr = {sr[6:0], din};
  wire logic decoding = (st == ST_OPC) | (st == ST_ADR) | (st == ST_SWR) | (st == ST_AWR);
  wire logic byte_done = sck_rise & decoding & (bcnt == 3'h7);
  wire logic opc_done = byte_done & (st == ST_OPC);
  wire logic rd_mode = (st == ST_SRD) | (st == ST_ARD);
  wire logic ok_byte = got & (bcnt == 3'h0);
  wire logic [1:0] top_bits = arr_addr[SEP_ADDR_HI:SEP_ADDR_HI-1];
  // Guard region: 01 upper quarter, 10 upper half, 11 all
  wire logic prot = (guard_hi_bit & guard_lo_bit) |
                    (guard_hi_bit & top_bits[1]) |
                    (guard_lo_bit & (top_bits == 2'h3));
  wire logic swr_ok = write_latch_bit & ~busy_flag & ~hard_guard_mode;
  wire logic swr_go = sel_rise & (st == ST_SWR) & ok_byte & swr_ok;
  wire logic awr_ok = write_latch_bit & ~busy_flag & ~prot;
  wire logic awr_go = sel_rise & (st == ST_AWR) & ok_byte & awr_ok;
  wire logic t_end = busy_flag & (timer == 32'(WRITE_CYC - 1));

  // Hard mode follows pin and lock levels, so entry order does not matter
  assign hard_guard_mode = status_lock_bit & ~wp_n_s;

  // Status byte as shifted out
  assign status_byte[SEP_B_BUSY] = busy_flag;
  assign status_byte[SEP_B_WL] = write_latch_bit;
  assign status_byte[SEP_B_GLO] = guard_lo_bit;
  assign status_byte[SEP_B_GHI] = guard_hi_bit;
  assign status_byte[SEP_B_ZHI:SEP_B_ZLO] = 3'h0;
  assign status_byte[SEP_B_LOCK] = status_lock_bit;

  // Next state after a completed byte
  always_comb begin
    next_st = st;
    unique case (st)
      ST_OPC: begin
        if (sep_op_bytes(next_sr) == 3'h0) begin
          next_st = ST_WAIT;
        end else if (next_sr == SEP_OP_RD_ST) begin
          next_st = ST_SRD;
        end else if (next_sr == SEP_OP_WR_ST) begin
          next_st = ST_SWR;
        end else if (next_sr == SEP_OP_RD_ARR) begin
          next_st = busy_flag ? ST_WAIT : ST_ADR;
        end else if (next_sr == SEP_OP_WR_ARR) begin
          next_st = ST_ADR;
        end else begin
          next_st = ST_WAIT;
        end
      end
      ST_ADR: begin
        if (abyte) begin
          next_st = (op == SEP_OP_RD_ARR) ? ST_ARD : ST_AWR;
        end
      end
      ST_IDLE, ST_WAIT, ST_SRD, ST_SWR, ST_ARD, ST_AWR: next_st = st;
      default: next_st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Input shifter and sequencing
  // ----------------------------------------------------------------
  // Only a select fall arms the decoder; select held low out of reset reads as a fall
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= ST_IDLE;
      bcnt <= 3'h0;
      sr <= 8'h00;
      abyte <= 1'b0;
      got <= 1'b0;
      op <= 8'h00;
    end else if (sel_rise) begin
      st <= ST_IDLE;
    end else if (sel_fall) begin
      st <= ST_OPC;
      bcnt <= 3'h0;
      abyte <= 1'b0;
      got <= 1'b0;
    end else if (sck_rise & (st != ST_IDLE)) begin
      bcnt <= bcnt + 3'h1;
      sr <= next_sr;
      if (byte_done) begin
        st <= next_st;
        if (st == ST_OPC) begin
          op <= next_sr;
        end
        if (st == ST_ADR) begin
          abyte <= 1'b1;
        end
        if ((st == ST_SWR) | (st == ST_AWR)) begin
          got <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, latch and self-timed cycle
  // ----------------------------------------------------------------
  // Guard and lock bits are written only at the end of the timed cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_flag <= 1'b0;
      write_latch_bit <= 1'b0;
      {status_lock_bit, guard_hi_bit, guard_lo_bit} <= SEP_NV_RST;
      pend <= SEP_NV_RST;
      pend_st <= 1'b0;
      timer <= 32'h0;
    end else begin
      if (swr_go | awr_go) begin
        busy_flag <= 1'b1;
        pend_st <= swr_go;
        timer <= 32'h0;
      end else if (t_end) begin
        busy_flag <= 1'b0;
        write_latch_bit <= 1'b0;
        if (pend_st) begin
          {status_lock_bit, guard_hi_bit, guard_lo_bit} <= pend;
        end
      end else if (busy_flag) begin
        timer <= timer + 32'h1;
      end else if (opc_done & (next_sr == SEP_OP_SET_WL)) begin
        write_latch_bit <= 1'b1;
      end else if (opc_done & (next_sr == SEP_OP_CLR_WL)) begin
        write_latch_bit <= 1'b0;
      end
      // Only lock and guard bits are taken from the data byte; a refused
      // status write during a timed cycle must not disturb the pending value
      if (byte_done & (st == ST_SWR) & ~busy_flag) begin
        pend <= {next_sr[SEP_B_LOCK], next_sr[SEP_B_GHI], next_sr[SEP_B_GLO]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Source byte is reloaded every eight falls, so status stays live
  wire logic [7:0] out_src = (st == ST_SRD) ? status_byte : arr_rd_byte;
  wire logic out_load = sck_fall & rd_mode & (ocnt == 3'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      miso_q <= 1'b0;
      oe_q <= 1'b0;
      osr <= 8'h00;
      ocnt <= 3'h0;
    end else if (sel_rise | sel_fall) begin
      oe_q <= 1'b0;
      ocnt <= 3'h0;
    end else if (sck_fall & rd_mode) begin
      oe_q <= 1'b1;
      ocnt <= ocnt + 3'h1;
      if (out_load) begin
        miso_q <= out_src[7];
        osr <= {out_src[6:0], 1'b0};
      end else begin
        miso_q <= osr[7];
        osr <= {osr[6:0], 1'b0};
      end
    end
  end

  assign link.miso = miso_q;
  assign link.miso_oe = oe_q;

  // ----------------------------------------------------------------
  // Array side handshake
  // ----------------------------------------------------------------
  // Write bytes wrap inside the page; reads wrap over the used bits
  always_ff @(posedge clk) begin
    if (rst) begin
      arr_addr <= 16'h0000;
      arr_wr_vld <= 1'b0;
      arr_wr_byte <= 8'h00;
      arr_wr_commit <= 1'b0;
    end else begin
      arr_wr_vld <= byte_done & (st == ST_AWR) & awr_ok;
      arr_wr_commit <= awr_go;
      if (byte_done & (st == ST_AWR)) begin
        arr_wr_byte <= next_sr;
      end
      if (byte_done & (st == ST_ADR)) begin
        arr_addr <= {arr_addr[7:0], next_sr};
      end else if (arr_wr_vld) begin
        arr_addr[SEP_PAGE_HI:0] <= arr_addr[SEP_PAGE_HI:0] + {{SEP_PAGE_HI{1'b0}}, 1'b1};
      end else if (out_load & (st == ST_ARD)) begin
        arr_addr[SEP_ADDR_HI:0] <= arr_addr[SEP_ADDR_HI:0] + {{SEP_ADDR_HI{1'b0}}, 1'b1};
      end
    end
  end

endmodule

//--- inc/sep_pkg.sv
package sep_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SEP_OP_SET_WL = 8'h06;
  localparam logic [7:0] SEP_OP_CLR_WL = 8'h04;
  localparam logic [7:0] SEP_OP_RD_ST = 8'h05;
  localparam logic [7:0] SEP_OP_WR_ST = 8'h01;
  localparam logic [7:0] SEP_OP_RD_ARR = 8'h03;
  localparam logic [7:0] SEP_OP_WR_ARR = 8'h02;

  // ----------------------------------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------------------------------
  localparam int SEP_B_BUSY = 0;
  localparam int SEP_B_WL = 1;
  localparam int SEP_B_GLO = 2;
  localparam int SEP_B_GHI = 3;
  localparam int SEP_B_ZHI = 6;
  localparam int SEP_B_ZLO = 4;
  localparam int SEP_B_LOCK = 7;
  // Delivery state of the lock and guard bits
  localparam logic [2:0] SEP_NV_RST = 3'h0;
  // Idle pin levels: {select_n, clock, data in, write protect_n}
  localparam logic [3:0] SEP_PIN_IDLE = 4'h9;

  // ----------------------------------------------------------------
  // Address fields
  // ----------------------------------------------------------------
  localparam int SEP_ADDR_HI = 11;
  localparam int SEP_PAGE_HI = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SEP_CLK_NS = 25;
  localparam int SEP_WRITE_TIME_NS = 1000000;
  localparam int SEP_WRITE_CYC = SEP_WRITE_TIME_NS / SEP_CLK_NS;
  // Host link clock half period, in system clocks
  localparam logic [3:0] SEP_HOST_HALF = 4'h8;

  // Bytes of a whole instruction; zero marks an unknown code
  function automatic logic [2:0] sep_op_bytes(input logic [7:0] op);
    case (op)
      SEP_OP_SET_WL, SEP_OP_CLR_WL: sep_op_bytes = 3'h1;
      SEP_OP_RD_ST, SEP_OP_WR_ST: sep_op_bytes = 3'h2;
      SEP_OP_RD_ARR, SEP_OP_WR_ARR: sep_op_bytes = 3'h4;
      default: sep_op_bytes = 3'h0;
    endcase
  endfunction

endpackage

//--- inc/sep_link_if.sv
`timescale 1ns/10ps
interface sep_link_if;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic wp_n;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // Serial output line is pulled up while nobody drives it
  assign miso_line = miso_oe ? miso : 1'b1;

  modport dev(input sel_n, input sclk, input mosi, input wp_n, output miso, output miso_oe);
  modport host(output sel_n, output sclk, output mosi, output wp_n, input miso_line);
endinterface

//--- design/sep_host.sv
`timescale 1ns/10ps
module sep_host
  import sep_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  sep_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic wp_n_in,
  output logic rsp_valid,
  output logic [7:0] rsp_byte
);

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_SETUP = 6'h02,
    H_HI = 6'h04,
    H_LO = 6'h08,
    H_DONE = 6'h10,
    H_GAP = 6'h20
  } sep_host_st_t;

  sep_host_st_t hst;
  logic [3:0] hcnt;
  logic sel_n_q;
  logic sclk_q;
  logic wp_q;
  logic [31:0] tx;
  logic [5:0] bits;
  logic [7:0] rx;
  logic m1;
  logic m2;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Unknown codes are still sent as a lone byte
  wire logic [2:0] nb = sep_op_bytes(cmd_op);
  wire logic [2:0] nb_eff = (nb == 3'h0) ? 3'h1 : nb;
  wire logic [31:0] tx_new = (nb == 3'h2) ? {cmd_op, cmd_data, 16'h0000}
                                         : {cmd_op, cmd_addr, cmd_data};
  wire logic tick = (hcnt == SEP_HOST_HALF - 4'h1);
  wire logic take = cmd_valid & (hst == H_IDLE);

  assign cmd_ready = (hst == H_IDLE);
  assign link.sel_n = sel_n_q;
  assign link.sclk = sclk_q;
  assign link.mosi = tx[31];
  assign link.wp_n = wp_q;

  // ----------------------------------------------------------------
  // Serial input synchroniser and protect pin register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      m1 <= 1'b1;
      m2 <= 1'b1;
      wp_q <= 1'b1;
    end else begin
      m1 <= link.miso_line;
      m2 <= m1;
      wp_q <= wp_n_in;
    end
  end

  // ----------------------------------------------------------------
  // Clock divider and transfer sequencer
  // ----------------------------------------------------------------
  // Half period is long enough to see the device's synchronised output
  always_ff @(posedge clk) begin
    if (rst | (hst == H_IDLE) | tick) begin
      hcnt <= 4'h0;
    end else begin
      hcnt <= hcnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hst <= H_IDLE;
      sel_n_q <= 1'b1;
      sclk_q <= 1'b0;
      tx <= 32'h0;
      bits <= 6'h0;
      rx <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_byte <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      if (take) begin
        sel_n_q <= 1'b0;
        tx <= tx_new;
        bits <= {nb_eff, 3'h0};
        hst <= H_SETUP;
      end else if (tick & ((hst == H_SETUP) | (hst == H_LO))) begin
        sclk_q <= 1'b1;
        rx <= {rx[6:0], m2};
        hst <= H_HI;
      end else if (tick & (hst == H_HI)) begin
        sclk_q <= 1'b0;
        bits <= bits - 6'h1;
        if (bits == 6'h1) begin
          hst <= H_DONE;
        end else begin
          tx <= {tx[30:0], 1'b0};
          hst <= H_LO;
        end
      end else if (tick & (hst == H_DONE)) begin
        sel_n_q <= 1'b1;
        rsp_valid <= 1'b1;
        rsp_byte <= rx;
        hst <= H_GAP;
      end else if (tick & (hst == H_GAP)) begin
        hst <= H_IDLE;
      end
    end
  end

endmodule

//--- dv/sep_checker.sv
`timescale 1ns/10ps
module sep_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic wp_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Link phase sequences
  // ----------------------------------------------------------------
  // Host holds each link clock phase for eight system clocks
  sequence s_clk_high;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence s_setup;
    !sclk [*8];
  endsequence

  // ----------------------------------------------------------------
  // Wire rules
  // ----------------------------------------------------------------
  a_clk_high_half: assert property ($rose(sclk) |-> s_clk_high)
    else $error("link clock high phase has the wrong length");
  a_sel_setup: assert property ($fell(sel_n) |-> s_setup)
    else $error("link clock moved too soon after select fell");
  a_mosi_stable_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("serial input changed while link clock high");
  a_sel_clk_low: assert property ($changed(sel_n) |-> !sclk)
    else $error("select moved while link clock high");
  a_oe_release: assert property ($rose(sel_n) |-> ##[1:5] !miso_oe)
    else $error("output still driven after deselect");
  a_oe_idle_quiet: assert property (sel_n [*6] |-> !miso_oe)
    else $error("output driven while deselected");
  a_miso_on_low: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk)
    else $error("serial output changed while link clock high");
  a_oe_start_low: assert property ($rose(miso_oe) |-> !sel_n && !sclk)
    else $error("output enabled outside a low clock phase");
  a_idle_line_high: assert property (sel_n [*6] |-> miso_line)
    else $error("serial output line not released while deselected");
endmodule

//--- dv/serial_eeprom_cmd_status_protect_bench.sv
`timescale 1ns/10ps
module serial_eeprom_cmd_status_protect_bench;
  import sep_pkg::*;
  localparam int WCYC = 600;
  logic clk;
  logic rst;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_op;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_data;
  logic wp_n_in;
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic busy_flag;
  logic write_latch_bit;
  logic guard_hi_bit;
  logic guard_lo_bit;
  logic status_lock_bit;
  logic hard_guard_mode;
  logic [7:0] arr_rd_byte;
  logic arr_wr_commit;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int commits = 0;
  integer seed = 32'hA9469C88;
  int m_lock, m_ghi, m_glo, m_wl;
  logic [7:0] d;
  logic [15:0] arr_addr;
  logic arr_wr_vld;
  logic [7:0] arr_wr_byte;
  logic [15:0] wr_addr_seen;
  logic [7:0] wr_byte_seen;
  logic [7:0] mem [0:15];
  // Which flag wait_flag watches
  localparam int FL_RSP = 0;
  localparam int FL_RDY = 1;
  localparam int FL_BUSY = 2;

  sep_link_if link_if();
  sep_host sep_host_inst(.clk(clk), .rst(rst), .link(link_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .wp_n_in(wp_n_in), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
  sep_device #(.WRITE_CYC(WCYC)) sep_device_inst(.clk(clk), .rst(rst), .link(link_if),
    .busy_flag(busy_flag), .write_latch_bit(write_latch_bit), .guard_hi_bit(guard_hi_bit),
    .guard_lo_bit(guard_lo_bit), .status_lock_bit(status_lock_bit),
    .hard_guard_mode(hard_guard_mode), .arr_addr(arr_addr), .arr_rd_byte(arr_rd_byte),
    .arr_wr_vld(arr_wr_vld), .arr_wr_byte(arr_wr_byte), .arr_wr_commit(arr_wr_commit));
  sep_checker sep_checker_inst(.clk(clk), .rst(rst), .sel_n(link_if.sel_n),
    .sclk(link_if.sclk), .mosi(link_if.mosi), .wp_n(link_if.wp_n), .miso(link_if.miso),
    .miso_oe(link_if.miso_oe), .miso_line(link_if.miso_line));

  // ----------------------------------------------------------------
  // Clock, memory data, commit count and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Small random memory behind the address the device presents; write bytes are logged
  always @(posedge clk) begin
    arr_rd_byte <= mem[arr_addr[3:0]];
    cycles++;
    if (arr_wr_commit === 1'b1) commits++;
    if (arr_wr_vld === 1'b1) begin
      wr_addr_seen <= arr_addr;
      wr_byte_seen <= arr_wr_byte;
    end
    if (cycles == 30000) begin
      n_fail++;
      $display("wrong value at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Model and shared tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_st(input int busy);
    exp_st = {1'(m_lock), 3'h0, 1'(m_ghi), 1'(m_glo), 1'(m_wl), 1'(busy)};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait on a flag with a ceiling so a stuck design cannot hang the run
  function automatic logic flag_of(input int k);
    flag_of = (k == FL_RSP) ? rsp_valid : (k == FL_RDY) ? cmd_ready : busy_flag;
  endfunction

  task automatic wait_flag(input int k, input logic lvl, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (flag_of(k) !== lvl && n < lim);
    if (flag_of(k) !== lvl) chk(8'hEE, 8'h00);
  endtask

  task automatic send(input logic [7:0] op, input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk);
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_data <= data;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    wait_flag(FL_RSP, 1'b1, 3000);
    wait_flag(FL_RDY, 1'b1, 100);
  endtask

  // Status over the wire and at the device's own outputs
  task automatic rd_status(input int busy);
    send(SEP_OP_RD_ST, 16'h0000, 8'h00);
    chk(rsp_byte, exp_st(busy));
    chk({status_lock_bit, 3'h0, guard_hi_bit, guard_lo_bit, write_latch_bit, busy_flag},
      exp_st(busy));
  endtask

  task automatic wr_status(input logic [7:0] v);
    send(SEP_OP_SET_WL, 16'h0000, 8'h00);
    send(SEP_OP_WR_ST, 16'h0000, v);
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_addr = 16'h0000;
    cmd_data = 8'h00;
    wp_n_in = 1'b1;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'($random(seed));
    end
    m_lock = 0;
    m_ghi = 0;
    m_glo = 0;
    m_wl = 0;
    // Two edges of reset; every pin stage resets to its idle level
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_status(0);
    send(SEP_OP_SET_WL, 16'h0000, 8'h00);
    m_wl = 1;
    rd_status(0);
    send(SEP_OP_CLR_WL, 16'h0000, 8'h00);
    m_wl = 0;
    rd_status(0);
    send(SEP_OP_WR_ST, 16'h0000, 8'h8C);
    rd_status(0);
    send(8'h86, 16'h0000, 8'h00);
    rd_status(0);
    // Random status byte; new values appear only after the timed cycle
    d = 8'($random(seed));
    wr_status(d);
    m_wl = 1;
    rd_status(1);
    wait_flag(FL_BUSY, 1'b0, WCYC + 50);
    m_lock = d[7];
    m_ghi = d[3];
    m_glo = d[2];
    m_wl = 0;
    rd_status(0);
    wr_status(8'h84);
    wait_flag(FL_BUSY, 1'b0, WCYC + 350);
    m_lock = 1;
    m_ghi = 0;
    m_glo = 1;
    rd_status(0);
    // Protect pin low with lock set: status write refused
    @(posedge clk);
    wp_n_in <= 1'b0;
    repeat (10) @(posedge clk);
    chk({7'h00, hard_guard_mode}, 8'h01);
    wr_status(8'h00);
    m_wl = 1;
    rd_status(0);
    // Upper address bits ignored: 0C10 lies in the guarded quarter
    send(SEP_OP_WR_ARR, 16'hFC10, 8'($random(seed)));
    rd_status(0);
    chk(8'(commits), 8'h00);
    d = 8'($random(seed));
    send(SEP_OP_WR_ARR, 16'h0010, d);
    #1;
    chk(8'(commits), 8'h01);
    chk(wr_byte_seen, d);
    chk(wr_addr_seen[15:8], 8'h00);
    chk(wr_addr_seen[7:0], 8'h10);
    wait_flag(FL_BUSY, 1'b0, WCYC + 50);
    m_wl = 0;
    rd_status(0);
    @(posedge clk);
    wp_n_in <= 1'b1;
    repeat (10) @(posedge clk);
    chk({7'h00, hard_guard_mode}, 8'h00);
    wr_status(8'h00);
    wait_flag(FL_BUSY, 1'b0, WCYC + 350);
    m_lock = 0;
    m_glo = 0;
    rd_status(0);
    // Array read: upper address bits ignored, byte comes from the memory
    send(SEP_OP_RD_ARR, 16'hF003, 8'h00);
    chk(rsp_byte, mem[3]);
    print_verdict();
  end
endmodule
